// >>> logic/dsi_pkg.sv
/*
  Shared constants for the drive status interlock: selector codes,
  current scale, deceleration allowance and the controller register map.
  Assumes a single 100 MHz clock domain on both ends.
*/
package dsi_pkg;
  localparam int unsigned CLK_MHZ = 100;
  // Status signal selector codes, positive logic; negative logic adds the offset
  localparam logic [7:0] SEL_RUNNING = 8'h00;
  localparam logic [7:0] SEL_READY = 8'h0b;
  localparam logic [7:0] SEL_CURRENT = 8'h0c;
  localparam logic [7:0] SEL_FAULT = 8'h63;
  localparam logic [7:0] SEL_NEG_OFFSET = 8'h64;
  // Selector defaults after reset: running, ready, fault
  localparam logic [7:0] SEL_A_RESET = SEL_RUNNING;
  localparam logic [7:0] SEL_B_RESET = SEL_READY;
  localparam logic [7:0] SEL_C_RESET = SEL_FAULT;
  localparam int unsigned N_TERM = 3;
  // Current in percent of rated current
  localparam logic [7:0] CUR_DETECT_RESET = 8'h96;
  localparam logic [7:0] CUR_NOLOAD_SUGGEST = 8'h14;
  // Power-up settle before the drive reports ready
  localparam int unsigned READY_DELAY_US = 10;
  localparam int unsigned READY_DELAY_CYC = READY_DELAY_US * CLK_MHZ;
  // Controller register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK = 8'h0c;
  localparam logic [7:0] REG_DECEL = 8'h10;
  localparam logic [7:0] REG_SPEED_TOL = 8'h14;
  localparam logic [7:0] REG_READY_TO = 8'h18;
  // Control register bits
  localparam int unsigned CTRL_FWD = 0;
  localparam int unsigned CTRL_REV = 1;
  localparam int unsigned CTRL_SPEED_LO = 8;
  localparam int unsigned CTRL_SPEED_W = 16;
  // Interrupt/status bits
  localparam int unsigned EV_FAULT = 0;
  localparam int unsigned EV_NOT_READY = 1;
  localparam int unsigned EV_RUN_MISMATCH = 2;
  localparam int unsigned EV_CUR_MISMATCH = 3;
  localparam int unsigned EV_BACKUP = 4;
  localparam int unsigned EV_SPEED_DEV = 5;
  localparam int unsigned N_EV = 6;
  localparam logic [31:0] DECEL_RESET = 32'h000f_4240;
  localparam logic [15:0] SPEED_TOL_RESET = 16'h0010;
  localparam logic [31:0] READY_TO_RESET = 32'h0000_2710;
endpackage : dsi_pkg

// >>> logic/dsi_if.sv
/*
  Interface joining the drive status end and the sequence controller end.
  Assumes both ends share clock and reset; terminals carry levels.
*/
`timescale 1ns/1ps
interface dsi_if;
  logic forward_start_in;
  logic reverse_start_in;
  logic [15:0] speed_cmd;
  logic [2:0] term_out;
  logic fault_relay_contact;
  modport drive (
    input forward_start_in,
    input reverse_start_in,
    input speed_cmd,
    output term_out,
    output fault_relay_contact
  );
  modport ctrl (
    output forward_start_in,
    output reverse_start_in,
    output speed_cmd,
    input term_out,
    input fault_relay_contact
  );
endinterface : dsi_if

// >>> logic/dsi_term_mux.sv
/*
  One output terminal selector: decodes a selector code into a status
  choice and polarity. Assumes status inputs are registered, same clock.
*/
`timescale 1ns/1ps
module dsi_term_mux (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [7:0] sel,
  input wire logic [3:0] status,
  output logic term
);
  import dsi_pkg::*;
  logic nxt_term;
  logic term_ff;
  logic [7:0] base;
  logic neg;

  always_comb begin
    neg = (sel >= SEL_NEG_OFFSET);
    base = neg ? sel - SEL_NEG_OFFSET : sel;
    unique case (base)
      SEL_RUNNING: nxt_term = status[0] ^ neg;
      SEL_READY: nxt_term = status[1] ^ neg;
      SEL_CURRENT: nxt_term = status[2] ^ neg;
      SEL_FAULT: nxt_term = status[3] ^ neg;
      default: nxt_term = 1'b0;
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      term_ff <= 1'b0;
    end else begin
      term_ff <= nxt_term;
    end
  end
  assign term = term_ff;
endmodule : dsi_term_mux

// >>> logic/dsi_drive.sv
/*
  Drive status end: trip, ready, running and current detect model with three
  selectable output terminals and the fault relay. Assumes the controller
  drives start commands on the same clock; stage activity and current come from the
  drive's power stage as plain inputs.
*/
`timescale 1ns/1ps
module dsi_drive (
  input wire logic clock,
  input wire logic arst_n,
  dsi_if.drive link,
  input wire logic protective_trip,
  input wire logic fault_reset,
  input wire logic output_active,
  input wire logic [7:0] output_current_pct,
  input wire logic [7:0] current_detect_level,
  input wire logic [7:0] output_terminal_selector_a,
  input wire logic [7:0] output_terminal_selector_b,
  input wire logic [7:0] output_terminal_selector_c,
  output logic drive_enable,
  output logic fault_status_out,
  output logic operation_ready_out,
  output logic running_out,
  output logic current_detected_out
);
  import dsi_pkg::*;
  logic [15:0] pwr_cnt_ff, nxt_pwr_cnt;
  logic fault_ff, nxt_fault;
  logic ready_ff, nxt_ready;
  logic run_ff, nxt_run;
  logic cur_ff, nxt_cur;
  logic en_ff, nxt_en;
  logic [7:0] sel [N_TERM];
  logic start;

  assign sel[0] = output_terminal_selector_a;
  assign sel[1] = output_terminal_selector_b;
  assign sel[2] = output_terminal_selector_c;
  assign start = link.forward_start_in | link.reverse_start_in;

  always_comb begin
    nxt_pwr_cnt = pwr_cnt_ff;
    if (pwr_cnt_ff != 16'(READY_DELAY_CYC)) begin
      nxt_pwr_cnt = pwr_cnt_ff + 16'h0001;
    end
    nxt_fault = fault_ff;
    if (protective_trip) begin
      nxt_fault = 1'b1;
    end else if (fault_reset) begin
      nxt_fault = 1'b0;
    end
    // Ready once power has settled and no trip holds the drive
    nxt_ready = (pwr_cnt_ff == 16'(READY_DELAY_CYC)) && !nxt_fault;
    nxt_en = nxt_ready && start;
    // Running stays high while the stage still outputs during deceleration
    nxt_run = !nxt_fault && (nxt_en || output_active);
    // Current flag follows the stage, so it too spans deceleration
    nxt_cur = !nxt_fault && output_active
      && (output_current_pct >= current_detect_level);
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pwr_cnt_ff <= 16'h0000;
      fault_ff <= 1'b0;
      ready_ff <= 1'b0;
      run_ff <= 1'b0;
      cur_ff <= 1'b0;
      en_ff <= 1'b0;
    end else begin
      pwr_cnt_ff <= nxt_pwr_cnt;
      fault_ff <= nxt_fault;
      ready_ff <= nxt_ready;
      run_ff <= nxt_run;
      cur_ff <= nxt_cur;
      en_ff <= nxt_en;
    end
  end

  assign drive_enable = en_ff;
  assign fault_status_out = fault_ff;
  assign operation_ready_out = ready_ff;
  assign running_out = run_ff;
  assign current_detected_out = cur_ff;

  genvar gi;
  generate
    for (gi = 0; gi < N_TERM; gi++) begin : g_term
      dsi_term_mux u_mux (
        .clock(clock),
        .arst_n(arst_n),
        .sel(sel[gi]),
        .status({fault_ff, cur_ff, ready_ff, run_ff}),
        .term(link.term_out[gi])
      );
    end
  endgenerate

  // Relay contact closed while healthy, opens on fault
  assign link.fault_relay_contact = !fault_ff;
endmodule : dsi_drive

// >>> logic/dsi_ctrl.sv
/*
  Sequence controller end: issues start commands and a speed command from
  APB registers and checks the drive status terminals and external detectors.
  Assumes terminal a carries running, b ready, c current detect in positive
  logic, and that detector inputs come from outside the clock domain.
*/
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/1ps
module dsi_ctrl (
  input wire logic clock,
  input wire logic arst_n,
  dsi_if.ctrl link,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] det_speed,
  input wire logic [2:0] det_phase_current,
  output logic irq
);
  import dsi_pkg::*;
  logic [31:0] ctrl_ff, nxt_ctrl;
  logic [N_EV-1:0] ist_ff, nxt_ist;
  logic [N_EV-1:0] imask_ff, nxt_imask;
  logic [31:0] decel_ff, nxt_decel;
  logic [15:0] tol_ff, nxt_tol;
  logic [31:0] rdyto_ff, nxt_rdyto;
  logic [31:0] allow_ff, nxt_allow;
  logic [31:0] rdycnt_ff, nxt_rdycnt;
  logic [31:0] prdata_ff, nxt_prdata;
  logic start_d_ff, nxt_start_d;
  // Detector inputs come from outside the clock domain
  logic [15:0] spd_s1_ff, spd_s2_ff;
  logic [2:0] cur_s1_ff, cur_s2_ff;
  // Terminal and relay levels, with two pad bits that stay low
  logic [5:0] term_s1_ff, term_s2_ff;
  logic [N_EV-1:0] ev;
  logic start, wr, rd, checking;
  logic run_t, rdy_t, cur_t, flt_t;
  logic [15:0] diff;

  // Decode of mapped offsets, used by the error path only
  function automatic logic known_addr(input logic [7:0] a);
    known_addr = (a == REG_CTRL) || (a == REG_STATUS) || (a == REG_IRQ_STAT)
      || (a == REG_IRQ_MASK) || (a == REG_DECEL) || (a == REG_SPEED_TOL)
      || (a == REG_READY_TO);
  endfunction : known_addr

  // Zero-wait slave: pready stays high, every access takes two cycles
  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !known_addr(paddr);
  assign prdata = prdata_ff;
  // Only a command the link carries counts; both directions set is none
  assign start = link.forward_start_in | link.reverse_start_in;
  // Terminal map: a running, b ready, c current detect, positive logic
  assign run_t = term_s2_ff[0];
  assign rdy_t = term_s2_ff[1];
  assign cur_t = term_s2_ff[2];
  assign flt_t = !term_s2_ff[3];
  assign link.forward_start_in = ctrl_ff[CTRL_FWD] && !ctrl_ff[CTRL_REV];
  assign link.reverse_start_in = ctrl_ff[CTRL_REV] && !ctrl_ff[CTRL_FWD];
  assign link.speed_cmd = ctrl_ff[CTRL_SPEED_LO +: CTRL_SPEED_W];
  // The allowance loads one cycle after a command change, so the change
  // cycle itself is held off too, or a stale terminal would raise an event
  assign checking = (allow_ff == 32'h0) && (start == start_d_ff);
  // Absolute speed error against the commanded value
  assign diff = (spd_s2_ff > link.speed_cmd) ? spd_s2_ff - link.speed_cmd
    : link.speed_cmd - spd_s2_ff;

  always_comb begin
    // Events are raw levels; the sticky status holds them for software
    ev = '0;
    // A trip is seen through the relay contact, which opens on fault
    ev[EV_FAULT] = flt_t;
    // Not ready once the power-up timeout has run out
    ev[EV_NOT_READY] = (rdycnt_ff >= rdyto_ff) && !rdy_t;
    ev[EV_RUN_MISMATCH] = checking && (start != run_t);
    ev[EV_CUR_MISMATCH] = checking && (start != cur_t);
    // Any silent phase while commanded, or any phase live after allowance
    ev[EV_BACKUP] = checking && (start ? (cur_s2_ff != 3'h7)
      : (cur_s2_ff != 3'h0));
    ev[EV_SPEED_DEV] = checking && start && (diff > tol_ff);
  end

  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_imask = imask_ff;
    nxt_decel = decel_ff;
    nxt_tol = tol_ff;
    nxt_rdyto = rdyto_ff;
    nxt_ist = ist_ff;
    // Writes land only at the access edge
    if (wr) begin
      unique case (paddr)
        REG_CTRL: nxt_ctrl = pwdata;
        REG_IRQ_STAT: nxt_ist = ist_ff & ~pwdata[N_EV-1:0];
        REG_IRQ_MASK: nxt_imask = pwdata[N_EV-1:0];
        REG_DECEL: nxt_decel = pwdata;
        REG_SPEED_TOL: nxt_tol = pwdata[15:0];
        REG_READY_TO: nxt_rdyto = pwdata;
        default: ;
      endcase
    end

    // Set wins over a clear in the same cycle
    nxt_ist = nxt_ist | ev;
    // Command may only start with a nonzero frequency set
    if (nxt_ctrl[CTRL_SPEED_LO +: CTRL_SPEED_W] == 16'h0) begin
      nxt_ctrl[CTRL_REV:CTRL_FWD] = 2'b00;
    end

    // A command change reloads the deceleration allowance
    nxt_start_d = start;
    nxt_allow = allow_ff;
    if (start != start_d_ff) begin
      nxt_allow = decel_ff;
    end else if (allow_ff != 32'h0) begin
      nxt_allow = allow_ff - 32'h1;
    end

    // Saturating count; a timeout lowered below it takes effect at once
    nxt_rdycnt = rdycnt_ff;
    if (rdycnt_ff < rdyto_ff) begin
      nxt_rdycnt = rdycnt_ff + 32'h1;
    end

    // Read data is captured in setup so it stands through the access
    nxt_prdata = prdata_ff;
    if (rd) begin
      unique case (paddr)
        REG_CTRL: nxt_prdata = ctrl_ff;
        REG_STATUS: nxt_prdata = {27'h0, checking, flt_t, cur_t, rdy_t, run_t};
        REG_IRQ_STAT: nxt_prdata = {26'h0, ist_ff};
        REG_IRQ_MASK: nxt_prdata = {26'h0, imask_ff};
        REG_DECEL: nxt_prdata = decel_ff;
        REG_SPEED_TOL: nxt_prdata = {16'h0, tol_ff};
        REG_READY_TO: nxt_prdata = rdyto_ff;
        default: nxt_prdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_ff <= 32'h0;
      ist_ff <= '0;
      imask_ff <= '0;
      decel_ff <= DECEL_RESET;
      tol_ff <= SPEED_TOL_RESET;
      rdyto_ff <= READY_TO_RESET;
      allow_ff <= 32'h0;
      rdycnt_ff <= 32'h0;
      prdata_ff <= 32'h0;
      start_d_ff <= 1'b0;
      spd_s1_ff <= 16'h0;
      spd_s2_ff <= 16'h0;
      cur_s1_ff <= 3'h0;
      cur_s2_ff <= 3'h0;
      term_s1_ff <= 6'h08;
      term_s2_ff <= 6'h08;
    end else begin
      ctrl_ff <= nxt_ctrl;
      ist_ff <= nxt_ist;
      imask_ff <= nxt_imask;
      decel_ff <= nxt_decel;
      tol_ff <= nxt_tol;
      rdyto_ff <= nxt_rdyto;
      allow_ff <= nxt_allow;
      rdycnt_ff <= nxt_rdycnt;
      prdata_ff <= nxt_prdata;
      start_d_ff <= nxt_start_d;
      // Two-flop synchronisers; only the second stage is read
      spd_s1_ff <= det_speed;
      spd_s2_ff <= spd_s1_ff;
      cur_s1_ff <= det_phase_current;
      cur_s2_ff <= cur_s1_ff;
      term_s1_ff <= {2'b00, link.fault_relay_contact, link.term_out};
      term_s2_ff <= term_s1_ff;
    end
  end

  // A set mask bit enables that event onto the level interrupt
  assign irq = |(ist_ff & imask_ff);
endmodule : dsi_ctrl

// >>> verif/dsi_checker.sv
/*
  Checker on the link between drive and controller ends.
  Assumes terminal a running, b ready, c current detect, positive logic.
*/
`timescale 1ns/1ps
module dsi_checker (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic forward_start_in,
  input wire logic reverse_start_in,
  input wire logic [15:0] speed_cmd,
  input wire logic [2:0] term_out,
  input wire logic fault_relay_contact
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  sequence run_start;
    ($rose(forward_start_in) || $rose(reverse_start_in)) && term_out[1] && fault_relay_contact;
  endsequence
  sequence cmd_drop;
    ($fell(forward_start_in) || $fell(reverse_start_in)) && term_out[0] && fault_relay_contact;
  endsequence
  AST_START_NEEDS_SPEED: assert property ((forward_start_in || reverse_start_in) |-> speed_cmd != 16'h0000)
    else $error("start issued with zero speed");
  AST_ONE_DIRECTION: assert property (!(forward_start_in && reverse_start_in))
    else $error("both directions commanded");
  AST_RUN_FOLLOWS_START: assert property (run_start |-> ##[1:4] term_out[0])
    else $error("running terminal did not follow start");
  AST_RUN_HOLDS_DECEL: assert property (cmd_drop |-> term_out[0] [*3])
    else $error("running terminal dropped at start of deceleration");
  AST_RUN_NEEDS_CMD: assert property ($rose(term_out[0]) |-> (forward_start_in || reverse_start_in))
    else $error("running terminal rose without start");
  AST_FAULT_STOPS_RUN: assert property ($fell(fault_relay_contact) |-> ##[1:4] !term_out[0])
    else $error("fault did not stop running");
  AST_FAULT_KEEPS_STOP: assert property (!fault_relay_contact [*5] |-> !term_out[0])
    else $error("running while faulted");
  AST_CUR_WITH_RUN: assert property ($fell(term_out[0]) |-> !term_out[2])
    else $error("current flag outlived running");
endmodule : dsi_checker

// >>> verif/drive_status_interlock_tb_top.sv
/*
  Testbench joining drive and controller ends; emulates the power stage.
  Assumes APB answers in the access cycle and terminal map a=0, b=11, c=12.
*/
`timescale 1ns/1ps
module drive_status_interlock_tb_top;
  import dsi_pkg::*;
  logic clock = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, irq, err, drive_enable, fault_status_out, operation_ready_out;
  logic running_out, current_detected_out, output_active = 1'b0;
  logic protective_trip = 1'b0, fault_reset = 1'b0;
  logic [15:0] det_speed = 16'h0;
  logic [2:0] det_phase_current = 3'h0;
  logic [7:0] output_current_pct = 8'h0, current_detect_level = CUR_NOLOAD_SUGGEST;
  logic [7:0] output_terminal_selector_a = SEL_RUNNING, output_terminal_selector_b = SEL_READY;
  logic [7:0] output_terminal_selector_c = SEL_CURRENT, cnt = 8'h0;
  logic [7:0] codes [4] = '{SEL_RUNNING, SEL_READY, SEL_CURRENT, SEL_FAULT};
  logic [3:0] idle = 4'b0010;
  int fails = 0, cmp_count = 0;
  dsi_if u_dsi_if ();
  dsi_drive u_dsi_drive (.clock, .arst_n, .link(u_dsi_if), .protective_trip, .fault_reset,
    .output_active, .output_current_pct, .current_detect_level, .output_terminal_selector_a,
    .output_terminal_selector_b, .output_terminal_selector_c, .drive_enable,
    .fault_status_out, .operation_ready_out, .running_out, .current_detected_out);
  dsi_ctrl u_dsi_ctrl (.clock, .arst_n, .link(u_dsi_if), .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .det_speed, .det_phase_current, .irq);
  dsi_checker u_dsi_checker (.clock, .arst_n, .forward_start_in(u_dsi_if.forward_start_in),
    .reverse_start_in(u_dsi_if.reverse_start_in), .speed_cmd(u_dsi_if.speed_cmd),
    .term_out(u_dsi_if.term_out), .fault_relay_contact(u_dsi_if.fault_relay_contact));
  initial forever #5 clock = ~clock;
  // Power stage keeps outputting 20 cycles after enable drops; current fades first
  always @(posedge clock) begin
    cnt <= drive_enable ? 8'h14 : (cnt != 8'h00 ? cnt - 8'h01 : cnt);
    output_active <= drive_enable || cnt != 8'h00;
    output_current_pct <= (drive_enable || cnt > 8'h03) ? 8'h1e : 8'h00;
    det_speed <= output_active ? 16'h0100 : 16'h0000;
    det_phase_current <= output_active ? 3'b111 : 3'b000;
  end
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : wait_cyc
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_word
  task automatic check_bit(input logic got, input logic exp);
    check_word({31'h0, got}, {31'h0, exp});
  endtask : check_bit
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check_word(rd, exp);
  endtask : rd_chk
  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test
  initial begin
    #200us;
    fails++;
    finish_test();
  end
  initial begin
    wait_cyc(5);
    arst_n <= 1'b1;
    wait_cyc(400);
    check_bit(operation_ready_out, 1'b0);
    rd_chk(REG_DECEL, DECEL_RESET);
    rd_chk(REG_SPEED_TOL, {16'h0000, SPEED_TOL_RESET});
    rd_chk(REG_READY_TO, READY_TO_RESET);
    rd_chk(REG_IRQ_MASK, 32'h0);
    rd_chk(8'h40, 32'h0);
    check_bit(err, 1'b1);
    wait_cyc(620);
    check_word({operation_ready_out, u_dsi_if.term_out}, 4'b1010);
    check_bit(u_dsi_if.fault_relay_contact, 1'b1);
    for (int i = 0; i < 8; i++) begin
      output_terminal_selector_c <= codes[i % 4] + (i > 3 ? SEL_NEG_OFFSET : 8'h00);
      wait_cyc(4);
      check_bit(u_dsi_if.term_out[2], idle[i % 4] ^ (i > 3));
    end
    protective_trip <= 1'b1;
    wait_cyc(4);
    check_bit(u_dsi_if.term_out[2], 1'b0);
    check_word({fault_status_out, u_dsi_if.fault_relay_contact}, 2'b10);
    apb(1'b0, REG_IRQ_STAT, 32'h0);
    check_bit(rd[EV_FAULT], 1'b1);
    protective_trip <= 1'b0;
    fault_reset <= 1'b1;
    wait_cyc(4);
    fault_reset <= 1'b0;
    wait_cyc(1010);
    check_bit(u_dsi_if.term_out[2], 1'b1);
    output_terminal_selector_c <= SEL_CURRENT;
    apb(1'b1, REG_DECEL, 32'h28);
    apb(1'b1, REG_IRQ_STAT, 32'h3f);
    apb(1'b1, REG_CTRL, 32'h0001_0001);
    wait_cyc(10);
    check_word({drive_enable, running_out, current_detected_out, u_dsi_if.term_out}, 6'h3f);
    wait_cyc(60);
    rd_chk(REG_IRQ_STAT, 32'h0);
    apb(1'b1, REG_CTRL, 32'h0);
    wait_cyc(3);
    check_word({u_dsi_if.forward_start_in, running_out, current_detected_out}, 3'b011);
    wait_cyc(40);
    check_word({running_out, current_detected_out}, 2'b00);
    rd_chk(REG_IRQ_STAT, 32'h0);
    apb(1'b1, REG_CTRL, 32'h0000_0002);
    wait_cyc(4);
    check_bit(u_dsi_if.reverse_start_in, 1'b0);
    apb(1'b1, REG_CTRL, 32'h0001_0003);
    wait_cyc(4);
    check_word({u_dsi_if.forward_start_in, u_dsi_if.reverse_start_in}, 2'b00);
    current_detect_level <= CUR_DETECT_RESET;
    apb(1'b1, REG_CTRL, 32'h0001_0002);
    wait_cyc(10);
    check_word({u_dsi_if.reverse_start_in, running_out, current_detected_out}, 3'b110);
    rd_chk(REG_IRQ_STAT, 32'h0);
    wait_cyc(50);
    rd_chk(REG_IRQ_STAT, 32'h1 << EV_CUR_MISMATCH);
    apb(1'b1, REG_IRQ_MASK, 32'h1 << EV_CUR_MISMATCH);
    check_bit(irq, 1'b1);
    apb(1'b1, REG_IRQ_MASK, 32'h0);
    check_bit(irq, 1'b0);
    apb(1'b1, REG_CTRL, 32'h0);
    wait_cyc(40);
    apb(1'b1, REG_IRQ_STAT, 32'h3f);
    rd_chk(REG_IRQ_STAT, 32'h0);
    apb(1'b1, REG_IRQ_MASK, 32'h0);
    check_bit(irq, 1'b0);
    current_detect_level <= CUR_NOLOAD_SUGGEST;
    apb(1'b1, REG_CTRL, 32'h0001_0001);
    wait_cyc(10);
    protective_trip <= 1'b1;
    wait_cyc(6);
    check_word({drive_enable, running_out, fault_status_out}, 3'b001);
    // Ready is low while tripped; an expired timeout must now flag it
    apb(1'b1, REG_READY_TO, 32'h0);
    apb(1'b0, REG_IRQ_STAT, 32'h0);
    check_bit(rd[EV_FAULT], 1'b1);
    check_bit(rd[EV_NOT_READY], 1'b1);
    finish_test();
  end
endmodule : drive_status_interlock_tb_top
